// File: hdl/tmr_pkg.sv
// Constants, register map and types shared by the magnetic readout design
package tmr_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int CYCLE_RATE_HZ = 50;
  localparam int CYCLE_PERIOD_NS = 1_000_000_000 / CYCLE_RATE_HZ;
  localparam int CYCLE_PERIOD_CYC = (CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MUX_SETTLE_NS = 2000;
  localparam int MUX_SETTLE_CYC = (MUX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STRAP_PULSE_NS = 1000;
  localparam int STRAP_PULSE_CYC = (STRAP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_NS = 2000;
  localparam int POR_CYC = (POR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Converter and result format
  localparam int ADC_W = 12;
  localparam logic [11:0] ADC_MID = 12'h800;
  localparam logic [11:0] FIELD_POS_MAX = 12'h7ff;
  localparam logic [15:0] FIELD_FULL_POS = 16'h7fff;
  localparam logic [1:0] AXIS_LAST = 2'h2;

  // ==========================================================
  // Register indices; the byte address on the register bus is four times the index
  localparam logic [3:0] REG_CFG_A = 4'h0;
  localparam logic [3:0] REG_CFG_B = 4'h1;
  localparam logic [3:0] REG_MODE = 4'h2;
  localparam logic [3:0] REG_X_HI = 4'h3;
  localparam logic [3:0] REG_Z_LO = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'h9;
  localparam logic [3:0] REG_ID_A = 4'ha;
  localparam logic [3:0] REG_ID_B = 4'hb;
  localparam logic [3:0] REG_ID_C = 4'hc;
  localparam logic [3:0] REG_IRQ_STAT = 4'hd;
  localparam logic [3:0] REG_IRQ_MASK = 4'he;
  localparam logic [3:0] REG_LAST = 4'he;
  localparam int REG_IDX_LSB = 2;
  localparam int REG_IDX_MSB = 5;

  // ==========================================================
  // Field positions and reset values
  localparam int CFGA_FLOW_POS = 0;
  localparam int CFGA_RATE_POS = 2;
  localparam int CFGB_DELAY_POS = 0;
  localparam int CFGB_GAIN_POS = 5;
  localparam int STAT_READY_POS = 0;
  localparam int STAT_LOCK_POS = 1;
  localparam int STAT_SUPPLY_POS = 2;
  localparam int IRQ_DATA_POS = 0;
  localparam int IRQ_SINGLE_POS = 1;
  localparam logic [7:0] CFGA_RESET = 8'h00;
  localparam logic [7:0] CFGB_RESET = 8'h20;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ==========================================================
  // Bus answers and link
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [6:0] I2C_SLAVE_ADDR = 7'h1e;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;

  typedef enum logic [1:0] {
    MODE_CONT = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_IDLE = 2'h2,
    MODE_SLEEP = 2'h3
  } tmr_mode_e;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'h0,
    SQ_SETTLE = 3'h1,
    SQ_CONV = 3'h3,
    SQ_SET = 3'h2,
    SQ_RST = 3'h6,
    SQ_STORE = 3'h7
  } tmr_seq_e;

  typedef enum logic [2:0] {
    IC_IDLE = 3'h0,
    IC_ADDR = 3'h1,
    IC_ACKA = 3'h3,
    IC_WDATA = 3'h2,
    IC_ACKW = 3'h6,
    IC_RDATA = 3'h7,
    IC_ACKR = 3'h5
  } tmr_i2c_e;

endpackage

// File: hdl/tmr_i2c_slave.sv
// Serial two-wire register slave: pointer write, byte writes and auto-incrementing reads
`timescale 1ns/1ps
module tmr_i2c_slave
#(
  parameter logic [6:0] SLAVE_ADDR = tmr_pkg::I2C_SLAVE_ADDR
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [3:0] reg_idx,
  input wire logic [7:0] rd_data,
  output logic rd_stb,
  output logic wr_stb,
  output logic [7:0] wr_data
);
  import tmr_pkg::*;

  // ==========================================================
  // Pin synchronisers and bus condition detection
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_q;
  logic sda_q;
  tmr_i2c_e state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic rw;
  logic first;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_q <= scl_sync[1];
      sda_q <= sda_sync[1];
    end
  end

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_det = scl_s && scl_q && sda_q && !sda_s;
  wire stop_det = scl_s && scl_q && !sda_q && sda_s;
  wire byte_done = (bit_cnt == I2C_BYTE_BITS);

  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;

  // ==========================================================
  // Byte engine, moves on the sampled clock edges
  always_ff @(posedge aclk)
  begin
    rd_stb <= 1'b0;
    wr_stb <= 1'b0;
    if (!aresetn)
    begin
      state <= IC_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      first <= 1'b0;
      sda_oe <= 1'b0;
      reg_idx <= 4'h0;
      wr_data <= 8'h00;
    end
    else if (start_det)
    begin
      state <= IC_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (stop_det)
    begin
      state <= IC_IDLE;
      sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state == IC_ADDR || state == IC_WDATA)
      begin
        shreg <= {shreg[6:0], sda_s};
        bit_cnt <= bit_cnt + 4'h1;
      end
      else if (state == IC_ACKR)
      begin
        // A not-acknowledge from the master ends the read burst
        state <= sda_s ? IC_IDLE : IC_ACKA;
      end
    end
    else if (scl_fall)
    begin
      case (state)
        IC_ADDR:
          if (byte_done)
          begin
            if (shreg[7:1] == SLAVE_ADDR)
            begin
              sda_oe <= 1'b1;
              rw <= shreg[0];
              state <= IC_ACKA;
            end
            else
              state <= IC_IDLE;
          end
        IC_ACKA:
          if (rw)
          begin
            shreg <= rd_data;
            sda_oe <= !rd_data[7];
            bit_cnt <= 4'h1;
            rd_stb <= 1'b1;
            reg_idx <= reg_idx + 4'h1;
            state <= IC_RDATA;
          end
          else
          begin
            sda_oe <= 1'b0;
            bit_cnt <= 4'h0;
            first <= 1'b1;
            state <= IC_WDATA;
          end
        IC_WDATA:
          if (byte_done)
          begin
            sda_oe <= 1'b1;
            state <= IC_ACKW;
            if (first)
              reg_idx <= shreg[3:0];
            else
            begin
              wr_stb <= 1'b1;
              wr_data <= shreg;
            end
          end
        IC_ACKW:
        begin
          sda_oe <= 1'b0;
          bit_cnt <= 4'h0;
          // The pointer byte itself must not advance the pointer
          if (!first)
            reg_idx <= reg_idx + 4'h1;
          first <= 1'b0;
          state <= IC_WDATA;
        end
        IC_RDATA:
          if (byte_done)
          begin
            sda_oe <= 1'b0;
            state <= IC_ACKR;
          end
          else
          begin
            sda_oe <= !shreg[6];
            shreg <= {shreg[6:0], 1'b0};
            bit_cnt <= bit_cnt + 4'h1;
          end
        default:
          sda_oe <= 1'b0;
      endcase
    end
  end

  idle_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == IC_IDLE) |=> !sda_oe || $past(start_det)) else $error("Data line held while bus idle");

endmodule

// File: hdl/tmr_readout.sv
// Three-axis magnetic readout: sequencer, result registers, register bus slave and serial slave
`timescale 1ns/1ps
module tmr_readout
#(
  parameter int AXI_ADDR_W = 8,
  parameter int PERIOD_CYC = tmr_pkg::CYCLE_PERIOD_CYC,
  parameter logic [6:0] SLAVE_ADDR = tmr_pkg::I2C_SLAVE_ADDR,
  parameter logic [7:0] ID_A = 8'h5a, // Arbitrary identification value
  parameter logic [7:0] ID_B = 8'h3b, // Arbitrary identification value
  parameter logic [7:0] ID_C = 8'h71 // Arbitrary identification value
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic regulator_en_in,
  output logic [1:0] mux_sel,
  output logic [2:0] gain_sel,
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [tmr_pkg::ADC_W-1:0] adc_data,
  output logic strap_set,
  output logic strap_reset,
  output logic sample_ready_pin,
  output logic irq
);
  import tmr_pkg::*;

  if (AXI_ADDR_W < REG_IDX_MSB + 2 || PERIOD_CYC < 1 || PERIOD_CYC >= (1 << 24))
    $error("tmr_readout: unsupported parameter value");

  // ==========================================================
  // Power-on reset stretch; everything else runs from run_n
  logic [7:0] por_cnt;
  wire run_n = (por_cnt == 8'h00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      por_cnt <= 8'(POR_CYC);
    else if (!run_n)
      por_cnt <= por_cnt - 8'h01;
  end

  // ==========================================================
  // Registers and state
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  tmr_mode_e mode;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [15:0] data_out [3];
  logic [15:0] res [3];
  logic [15:0] pend [3];
  logic [11:0] p0 [3];
  logic pend_valid;
  logic ready;
  logic locked;
  logic [1:0] supply_sync;
  tmr_seq_e state;
  logic [1:0] axis;
  logic pass;
  logic [15:0] tcnt;
  logic [31:0] pcnt;

  // ==========================================================
  // Register read view, shared by both buses
  logic [7:0] regv [16];
  assign regv[0] = cfg_a;
  assign regv[1] = cfg_b;
  assign regv[2] = {6'h00, mode};
  assign regv[3] = data_out[0][15:8];
  assign regv[4] = data_out[0][7:0];
  assign regv[5] = data_out[1][15:8];
  assign regv[6] = data_out[1][7:0];
  assign regv[7] = data_out[2][15:8];
  assign regv[8] = data_out[2][7:0];
  assign regv[9] = {5'h00, supply_sync[1], locked, ready};
  assign regv[10] = ID_A;
  assign regv[11] = ID_B;
  assign regv[12] = ID_C;
  assign regv[13] = {6'h00, irq_stat};
  assign regv[14] = {6'h00, irq_mask};
  assign regv[15] = 8'h00;

  // ==========================================================
  // Register bus slave; the serial slave's write takes precedence in a shared cycle
  logic aw_got;
  logic w_got;
  logic aw_ok;
  logic [3:0] aw_idx;
  logic [7:0] wdata_q;
  logic wstrb_q;
  logic [3:0] i2c_idx;
  logic i2c_rd;
  logic i2c_wr;
  logic [7:0] i2c_wdata;

  wire [3:0] ar_idx = araddr[REG_IDX_MSB:REG_IDX_LSB];
  wire ar_ok = (araddr[AXI_ADDR_W-1:REG_IDX_MSB+1] == '0) && (ar_idx <= REG_LAST);
  wire [3:0] aw_in_idx = awaddr[REG_IDX_MSB:REG_IDX_LSB];
  wire aw_in_ok = (awaddr[AXI_ADDR_W-1:REG_IDX_MSB+1] == '0) && (aw_in_idx <= REG_LAST);
  wire axi_do = aw_got && w_got && !bvalid && !i2c_wr;
  wire axi_rd = arvalid && arready;
  wire wr_en = i2c_wr || (axi_do && aw_ok && wstrb_q);
  wire [3:0] wr_idx = i2c_wr ? i2c_idx : aw_idx;
  wire [7:0] wr_val = i2c_wr ? i2c_wdata : wdata_q;

  assign awready = !aw_got && run_n;
  assign wready = !w_got && run_n;
  assign arready = !rvalid && run_n;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run_n)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_ok <= 1'b0;
      aw_idx <= 4'h0;
      wdata_q <= 8'h00;
      wstrb_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got <= 1'b1;
        aw_idx <= aw_in_idx;
        aw_ok <= aw_in_ok;
      end
      if (wvalid && wready)
      begin
        w_got <= 1'b1;
        wdata_q <= wdata[7:0];
        wstrb_q <= wstrb[0];
      end
      if (axi_do)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= aw_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (axi_rd)
      begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, ar_ok ? regv[ar_idx] : 8'h00};
        rresp <= ar_ok ? RESP_OKAY : RESP_DECERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  tmr_i2c_slave #(.SLAVE_ADDR(SLAVE_ADDR)) u_serial
  (
    .aclk(aclk),
    .aresetn(run_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .reg_idx(i2c_idx),
    .rd_data(regv[i2c_idx]),
    .rd_stb(i2c_rd),
    .wr_stb(i2c_wr),
    .wr_data(i2c_wdata)
  );

  // ==========================================================
  // Output data lock: on the register bus, reading the first data byte freezes the set and reading the last frees it; serial reads act one byte earlier
  wire lock_evt = (axi_rd && ar_ok && ar_idx == REG_X_HI) || (i2c_rd && i2c_idx == REG_X_HI);
  wire unlock_evt = (axi_rd && ar_ok && ar_idx == REG_Z_LO) || (i2c_rd && i2c_idx == REG_Z_LO);
  wire publish = (state == SQ_STORE);
  wire hold_new = locked || lock_evt;
  wire load_res = publish && !hold_new;
  wire load_pend = pend_valid && !locked && !lock_evt && !publish;
  wire single_done = publish && (mode == MODE_SINGLE);

  always_ff @(posedge aclk)
  begin
    if (!run_n)
    begin
      locked <= 1'b0;
      ready <= 1'b0;
      pend_valid <= 1'b0;
      supply_sync <= 2'h0;
    end
    else
    begin
      supply_sync <= {supply_sync[0], regulator_en_in};
      if (unlock_evt)
        locked <= 1'b0;
      else if (lock_evt)
        locked <= 1'b1;
      if (load_res || load_pend)
        ready <= 1'b1;
      else if (unlock_evt)
        ready <= 1'b0;
      if (publish && hold_new)
        pend_valid <= 1'b1;
      else if (load_pend)
        pend_valid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!run_n)
        data_out[i] <= 16'h0000;
      else if (load_res)
        data_out[i] <= res[i];
      else if (load_pend)
        data_out[i] <= pend[i];
      if (publish && hold_new)
        pend[i] <= res[i];
    end
  end

  // Complete data only, and never while a register bus host is part-way through the set
  assign sample_ready_pin = ready && !locked;

  // ==========================================================
  // Control registers; sticky event bits, set wins over a write-one-to-clear
  wire [1:0] irq_set = {single_done, load_res || load_pend};
  wire [1:0] irq_clr = (wr_en && wr_idx == REG_IRQ_STAT) ? wr_val[1:0] : 2'h0;

  always_ff @(posedge aclk)
  begin
    if (!run_n)
    begin
      cfg_a <= CFGA_RESET;
      cfg_b <= CFGB_RESET;
      mode <= MODE_IDLE;
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
    end
    else
    begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_en && wr_idx == REG_CFG_A)
        cfg_a <= wr_val;
      if (wr_en && wr_idx == REG_CFG_B)
        cfg_b <= wr_val;
      if (wr_en && wr_idx == REG_IRQ_MASK)
        irq_mask <= wr_val[1:0];
      if (wr_en && wr_idx == REG_MODE)
        mode <= tmr_mode_e'(wr_val[1:0]);
      else if (single_done)
        mode <= MODE_IDLE;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // ==========================================================
  // Measurement sequencer
  wire [2:0] rate = cfg_a[CFGA_RATE_POS +: 3];
  wire same_pol = cfg_a[CFGA_FLOW_POS];
  wire [15:0] settle_len = 16'(MUX_SETTLE_CYC) << cfg_b[CFGB_DELAY_POS +: 2];
  wire [31:0] period_len = 32'(PERIOD_CYC) << rate;
  wire period_hit = (pcnt >= period_len - 32'h1);
  wire start = (state == SQ_IDLE) && ((mode == MODE_CONT && period_hit) || mode == MODE_SINGLE);

  assign mux_sel = axis;
  assign gain_sel = cfg_b[CFGB_GAIN_POS +: 3];
  assign strap_set = (state == SQ_SET);
  assign strap_reset = (state == SQ_RST);

  // Result = half the difference of the two polarities, which cancels bridge offset; with same_pol set, half the sum less midscale
  function automatic logic [15:0] to_field(input logic [11:0] c1, input logic [11:0] c2, input logic same);
    logic [12:0] acc;
    logic [11:0] v;
    acc = same ? ({1'b0, c1} + {1'b0, c2}) : ({1'b0, c1} - {1'b0, c2});
    v = same ? (acc[12:1] ^ ADC_MID) : acc[12:1];
    return (v == FIELD_POS_MAX) ? FIELD_FULL_POS : {{4{v[11]}}, v};
  endfunction

  always_ff @(posedge aclk)
  begin
    pcnt <= (!run_n || period_hit) ? 32'h0 : pcnt + 32'h1;
    adc_start <= 1'b0;
    if (!run_n)
    begin
      state <= SQ_IDLE;
      axis <= 2'h0;
      pass <= 1'b0;
      tcnt <= 16'h0000;
    end
    else
    begin
      case (state)
        SQ_IDLE:
          if (start)
          begin
            axis <= 2'h0;
            pass <= 1'b0;
            tcnt <= settle_len;
            state <= SQ_SETTLE;
          end
        SQ_SETTLE:
          if (tcnt == 16'h0000)
          begin
            adc_start <= 1'b1;
            state <= SQ_CONV;
          end
          else
            tcnt <= tcnt - 16'h0001;
        SQ_CONV:
          if (adc_done)
          begin
            tcnt <= settle_len;
            state <= SQ_SETTLE;
            if (axis != AXIS_LAST)
              axis <= axis + 2'h1;
            else if (pass)
              state <= SQ_STORE;
            else if (same_pol)
            begin
              axis <= 2'h0;
              pass <= 1'b1;
            end
            else
            begin
              tcnt <= 16'(STRAP_PULSE_CYC);
              state <= SQ_SET;
            end
          end
        SQ_SET:
          if (tcnt == 16'h0000)
          begin
            tcnt <= 16'(STRAP_PULSE_CYC);
            state <= SQ_RST;
          end
          else
            tcnt <= tcnt - 16'h0001;
        SQ_RST:
          if (tcnt == 16'h0000)
          begin
            axis <= 2'h0;
            pass <= 1'b1;
            tcnt <= settle_len;
            state <= SQ_SETTLE;
          end
          else
            tcnt <= tcnt - 16'h0001;
        SQ_STORE:
          state <= SQ_IDLE;
        default:
          state <= SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (state == SQ_CONV && adc_done && !pass)
      p0[axis] <= adc_data;
    if (state == SQ_CONV && adc_done && pass)
      res[axis] <= to_field(p0[axis], adc_data, same_pol);
  end

  // ==========================================================
  // Checks
  set_then_reset_a: assert property (@(posedge aclk) disable iff (!run_n)
    $fell(strap_set) |-> strap_reset) else $error("Set pulse not followed by reset pulse");

  flip_after_pass_a: assert property (@(posedge aclk) disable iff (!run_n)
    $rose(strap_set) |-> !pass && axis == AXIS_LAST) else $error("Strap pulse before three axes done");

  store_second_pass_a: assert property (@(posedge aclk) disable iff (!run_n)
    (state == SQ_STORE) |-> pass && axis == AXIS_LAST) else $error("Store without second pass");

  data_format_a: assert property (@(posedge aclk) disable iff (!run_n)
    data_out[0] == FIELD_FULL_POS || data_out[0][15:11] == 5'h00 || data_out[0][15:11] == 5'h1f)
    else $error("Result not a sign-extended twelve-bit value");

  locked_stable_a: assert property (@(posedge aclk) disable iff (!run_n)
    locked && !unlock_evt |=> $stable(data_out[0]) && $stable(data_out[2])) else $error("Data changed while locked");

  unlock_clear_a: assert property (@(posedge aclk) disable iff (!run_n)
    unlock_evt && !load_res && !load_pend |=> !ready && !sample_ready_pin) else $error("Ready not cleared");

  single_idle_a: assert property (@(posedge aclk) disable iff (!run_n)
    single_done && !(wr_en && wr_idx == REG_MODE) |=> mode == MODE_IDLE ##1 state == SQ_IDLE)
    else $error("Single conversion did not return to idle");

  quiet_mode_a: assert property (@(posedge aclk) disable iff (!run_n)
    state == SQ_IDLE && (mode == MODE_IDLE || mode == MODE_SLEEP) |=> state == SQ_IDLE)
    else $error("Conversion started in idle or sleep");

  por_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !run_n |-> state == SQ_IDLE && !adc_start && !ready && !awready) else $error("Logic active during power-on reset");

  event_sticky_a: assert property (@(posedge aclk) disable iff (!run_n)
    load_res |=> irq_stat[IRQ_DATA_POS] && ready) else $error("New data event lost");

endmodule

// File: verification/tmr_adc_model.sv
// Converter model: answers each conversion request with a fixed field per axis
`timescale 1ns/1ps
module tmr_adc_model
(
  input wire logic aclk,
  input wire logic adc_start,
  input wire logic [1:0] mux_sel,
  output logic adc_done,
  output logic [11:0] adc_data
);
  // ==========
  // Conversion
  logic [11:0] fld [3] = '{12'h7ff, 12'h000, 12'hffb};
  logic [3:0] sh = 4'h0;
  logic [2:0] n = 3'h0;
  initial {adc_done, adc_data} = '0;
  always @(posedge aclk)
  begin
    sh <= {sh[2:0], adc_start};
    adc_done <= sh[3];
    // Data walks between results so a stale sample cannot match
    adc_data <= ~adc_data;
    if (sh[3])
    begin
      adc_data <= n < 3'h3 ? 12'h800 + fld[mux_sel] : 12'h800 - fld[mux_sel];
      n <= n == 3'h5 ? 3'h0 : n + 3'h1;
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the magnetic readout over its register bus and its serial link
`timescale 1ns/1ps
module testbench;
  import tmr_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, regulator_en_in;
  logic awready, wready, bvalid, arready, rvalid, sda_out, sda_oe, adc_start, adc_done;
  logic strap_set, strap_reset, sample_ready_pin, irq;
  logic [1:0] bresp, rresp, mux_sel;
  logic [2:0] gain_sel;
  logic [7:0] awaddr, araddr, sup;
  logic [31:0] wdata, rdata;
  logic [11:0] adc_data;
  logic [33:0] q [$];
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rs = 32'd31;
  logic [7:0] ids [3] = '{8'h5a, 8'h3b, 8'h71};
  logic [7:0] res [6] = '{8'h7f, 8'hff, 8'h00, 8'h00, 8'hff, 8'hfb};
  logic scl, sda_m, ack;
  logic [7:0] got;
  // Open-drain data line: once both sides let go the pull-up wins
  wire sda_line = sda_m && (!sda_oe || sda_out);

  // ==========
  // Design and converter
  // Serial host runs its clock pin at 160 ns and shares the data line
  tmr_readout #(.PERIOD_CYC(200)) u_tmr_readout (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .regulator_en_in, .mux_sel, .gain_sel,
    .adc_start, .adc_done, .adc_data, .strap_set, .strap_reset, .sample_ready_pin, .irq);
  tmr_adc_model u_tmr_adc_model (.aclk, .adc_start, .mux_sel, .adc_done, .adc_data);

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ==========
  // Helpers
  task automatic stop_test();
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    q.push_back({r, 24'h0, d});
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // One serial bit: data set in the low phase, sampled late in the high phase
  task automatic i2c_bit(input logic b, output logic s);
    sda_m <= b;
    repeat (2) @(posedge aclk);
    scl <= 1'b1;
    repeat (3) @(posedge aclk);
    s = sda_line;
    @(posedge aclk);
    scl <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic i2c_byte(input logic [7:0] d, input logic ack_m, output logic [7:0] g, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      i2c_bit(d[i], s);
      g[i] = s;
    end
    i2c_bit(ack_m, a);
  endtask

  task automatic i2c_send(input logic [7:0] d);
    logic [7:0] g;
    logic a;
    i2c_byte(d, 1'b1, g, a);
    cmp(34'(a), 34'h0);
  endtask

  task automatic i2c_start();
    sda_m <= 1'b1;
    repeat (2) @(posedge aclk);
    scl <= 1'b1;
    repeat (4) @(posedge aclk);
    sda_m <= 1'b0;
    repeat (4) @(posedge aclk);
    scl <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic i2c_stop();
    sda_m <= 1'b0;
    repeat (2) @(posedge aclk);
    scl <= 1'b1;
    repeat (4) @(posedge aclk);
    sda_m <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (rvalid && rready)
      cmp({rresp, rdata}, q.pop_front());
    if (bvalid && bready)
      cmp({bresp, 32'h0}, q.pop_front());
    if (cyc > 8000)
    begin
      n_fail++;
      stop_test();
    end
  end

  // ==========
  // Sequence
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, regulator_en_in, awaddr, araddr, wdata} = '0;
    {scl, sda_m} = 2'h3;
    rs = xorshift(rs);
    sup = {5'h0, rs[17], 2'h0};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    regulator_en_in <= rs[17];
    for (int i = 0; i < 3; i++) rd(8'h28 + 8'(4 * i), ids[i]);
    rd(8'h04, 8'h20);
    rd(8'h08, 8'h02);
    rd(8'h3c, 8'h00, RESP_DECERR);
    wr(8'h3c, 8'hff, RESP_DECERR);
    wr(8'h04, 8'he0);
    cmp(34'(gain_sel), 34'h7);
    wr(8'h38, 8'h02);
    wr(8'h08, 8'h01);
    for (int i = 0; i < 3000 && irq !== 1'b1; i++) @(posedge aclk);
    @(posedge aclk);
    cmp(34'(irq), 34'h1);
    cmp(34'(sample_ready_pin), 34'h1);
    rd(8'h08, 8'h02);
    rd(8'h24, sup | 8'h01);
    rd(8'h0c, res[0]);
    rd(8'h24, sup | 8'h03);
    cmp(34'(sample_ready_pin), 34'h0);
    for (int i = 1; i < 6; i++) rd(8'h0c + 8'(4 * i), res[i]);
    rd(8'h24, sup);
    rd(8'h34, 8'h03);
    wr(8'h34, 8'h02);
    rd(8'h34, 8'h01);
    cmp(34'(irq), 34'h0);
    // Serial host: point at the first result byte, burst-read all six, then write the mask
    i2c_start();
    i2c_send({I2C_SLAVE_ADDR, 1'b0});
    i2c_send({4'h0, REG_X_HI});
    i2c_start();
    i2c_send({I2C_SLAVE_ADDR, 1'b1});
    for (int i = 0; i < 6; i++)
    begin
      i2c_byte(8'hff, i == 5, got, ack);
      cmp(34'(got), 34'(res[i]));
    end
    i2c_stop();
    i2c_start();
    i2c_send({I2C_SLAVE_ADDR, 1'b0});
    i2c_send({4'h0, REG_IRQ_MASK});
    i2c_send(8'h03);
    i2c_stop();
    rd(8'h38, 8'h03);
    cmp(34'(irq), 34'h1);
    @(posedge aclk);
    stop_test();
  end
endmodule
